// >>> i2cs_defines.svh
`ifndef I2CS_DEFINES_SVH
`define I2CS_DEFINES_SVH

// ****************************************
// Bus addressing
// ****************************************
`define I2CS_SLAVE_ADDR 7'h1d
`define I2CS_DIR_READ 1'b1

// ****************************************
// Bit counter positions within a byte slot
// ****************************************
`define I2CS_CNT_ZERO 4'h0
`define I2CS_CNT_ONE 4'h1
`define I2CS_BIT_LAST 4'h7
`define I2CS_ACK_SLOT 4'h8
`define I2CS_MSB_IDX 3'h7

// ****************************************
// Register pointer and transmit byte reset
// ****************************************
`define I2CS_PTR_RESET 8'h00
`define I2CS_PTR_STEP 8'h01
`define I2CS_BYTE_RESET 8'h00

// ****************************************
// Event lanes crossing from the link into clk
// ****************************************
`define I2CS_EV_COUNT 4
`define I2CS_EV_PTR 0
`define I2CS_EV_WR 1
`define I2CS_EV_START 2
`define I2CS_EV_STOP 3
`define I2CS_EV_RESET 4'h0

`endif

// >>> i2cs_host_model.sv
`timescale 1ns/100ps
module i2cs_host_model (
	// Link
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	// ****************************************
	// Bus master, quarter-bit steps
	// ****************************************
	// 625 gives 400 kHz; the bench sets 2500 for 100 kHz, only while the bus is idle
	time q = 625;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic bitx(input logic d, output logic s);
		#q sda_low = !d;
		#q scl = 1'b1;
		#q s = sda;
		#q scl = 1'b0;
	endtask
	// Also serves as repeated start from a low clock
	task automatic start();
		#q sda_low = 1'b0;
		#q scl = 1'b1;
		#q sda_low = 1'b1;
		#q scl = 1'b0;
	endtask
	task automatic stop();
		#q sda_low = 1'b1;
		#q scl = 1'b1;
		#q sda_low = 1'b0;
		#q;
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitx(b[i], s);
		end
		bitx(1'b1, s);
		ack = !s;
	endtask
	task automatic rbyte(input logic mack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, b[i]);
		end
		bitx(!mack, s);
	endtask
endmodule

// >>> i2cs_pkg.sv
package i2cs_pkg;

	// ****************************************
	// Link transaction phases
	// ****************************************
	typedef enum logic [2:0] {
		I2CS_IDLE = 3'b000,
		I2CS_ADDR = 3'b001,
		I2CS_REG = 3'b010,
		I2CS_WDATA = 3'b011,
		I2CS_RDATA = 3'b100
	} i2cs_state_type;

	// ****************************************
	// One register write handed to the clk domain
	// ****************************************
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} i2cs_wr_type;

endpackage

// >>> i2cs_regmem.sv
`timescale 1ns/100ps
`include "i2cs_defines.svh"

module i2cs_regmem #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// Read port for the link
	input wire logic [AW-1:0] a_addr,
	output logic [DW-1:0] a_data,
	// Read port for the device core
	input wire logic [AW-1:0] b_addr,
	output logic [DW-1:0] b_data
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	// ****************************************
	// Storage, no reset on the array itself
	// ****************************************
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// ****************************************
	// Registered read data
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			a_data <= '0;
			b_data <= '0;
		end else begin
			a_data <= mem[a_addr];
			b_data <= mem[b_addr];
		end
	end

endmodule

// >>> i2cs_slave.sv
// Functional notes
// (R1) SDA falling while SCL high is start
// (R2) Bus busy from start until stop
// (R3) First byte: seven address bits, direction
// (R4) Join only on exact address match
// (R5) Fixed address 0011101, bytes 3B/3A
// (R6) Ninth clock is acknowledge, held low
// (R7) SDA rising while SCL high is stop
// (R8) Repeated start accepted mid transfer
// (R9) MSB first, bits change on falling edges
// (R10) Ack write address and register pointer byte
// (R11) After restart read, ack then send register
// (R12) Master NAKs last byte then stops
// (R13) Burst read advances pointer per byte
// (R14) Keep sending until master NAKs
// (R15) Works at 100 kHz and 400 kHz
// (R16) Single write stores one byte, acked
// (R17) Further write bytes go to next address
// (R18) Pointer survives repeated start
`timescale 1ns/100ps
`include "i2cs_defines.svh"

module i2cs_slave import i2cs_pkg::*; #(
	parameter int MEM_AW = 8
) (
	// System clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Two-wire link, scl clocks the link logic
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Device core read port
	input wire logic [MEM_AW-1:0] usr_addr,
	output logic [7:0] usr_data,
	// Write notification to the device core
	output logic wr_pulse,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	// Bus status
	output logic bus_busy
);

	// ****************************************
	// Bus conditions, clocked by SDA edges
	// ****************************************
	// Our own drive only moves while SCL is low, so it never fakes a condition.
	logic start_tgl;
	logic stop_tgl;

	always_ff @(negedge sda_i or negedge rst_n) begin
		if (!rst_n) begin
			start_tgl <= 1'b0;
		end else if (scl) begin
			start_tgl <= ~start_tgl; // (R1) (R8)
		end
	end

	always_ff @(posedge sda_i or negedge rst_n) begin
		if (!rst_n) begin
			stop_tgl <= 1'b0;
		end else if (scl) begin
			stop_tgl <= ~stop_tgl; // (R7)
		end
	end

	// ****************************************
	// Link domain: receive side on rising SCL
	// ****************************************
	logic start_seen;
	logic stop_seen;
	logic [3:0] bit_cnt;
	logic [6:0] shift;
	i2cs_state_type state;
	i2cs_state_type next_state;
	logic ack_pend;
	logic next_ack;
	logic [7:0] ptr;
	logic ptr_tgl;
	logic wr_tgl;
	i2cs_wr_type wr_req;
	logic [7:0] rd_hold;

	// Toggles are a half bit old when SCL rises, so reading them here is safe.
	wire start_new = start_tgl ^ start_seen;
	wire stop_new = stop_tgl ^ stop_seen;
	wire clean = !start_new && !stop_new;
	wire [7:0] rx_byte = {shift, sda_i}; // (R9)
	wire addr_hit = (rx_byte[7:1] == `I2CS_SLAVE_ADDR); // (R4) (R5)
	wire byte_done = (bit_cnt == `I2CS_BIT_LAST);
	wire ack_clock = (bit_cnt == `I2CS_ACK_SLOT);
	wire ptr_load = clean && byte_done && (state == I2CS_REG); // (R10)
	wire ptr_step = clean && byte_done && (state == I2CS_WDATA || state == I2CS_RDATA); // (R13) (R17)
	wire wr_fire = clean && byte_done && (state == I2CS_WDATA); // (R16)
	wire [7:0] next_ptr = ptr_load ? rx_byte : ptr + `I2CS_PTR_STEP;
	wire [3:0] next_cnt = start_new ? `I2CS_CNT_ONE : (ack_clock ? `I2CS_CNT_ZERO : bit_cnt + `I2CS_CNT_ONE);

	always_comb begin
		next_state = state;
		next_ack = 1'b0;
		if (start_new) begin
			next_state = I2CS_ADDR; // (R3) (R8)
		end else if (stop_new) begin
			next_state = I2CS_IDLE; // (R2)
		end else if (byte_done) begin
			case (state)
				I2CS_ADDR: begin
					if (addr_hit) begin
						next_ack = 1'b1; // (R10) (R11)
						next_state = (rx_byte[0] == `I2CS_DIR_READ) ? I2CS_RDATA : I2CS_REG; // (R3)
					end else begin
						next_state = I2CS_IDLE; // (R4)
					end
				end
				I2CS_REG: begin
					next_ack = 1'b1; // (R10)
					next_state = I2CS_WDATA;
				end
				I2CS_WDATA: begin
					next_ack = 1'b1; // (R16) (R17)
				end
				default: begin
					next_ack = 1'b0;
				end
			endcase
		end else if (ack_clock && state == I2CS_RDATA && sda_i) begin
			next_state = I2CS_IDLE; // (R12) (R14)
		end
	end

	// Pointer is not touched by a start, so a restart reads where the write left it.
	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			start_seen <= 1'b0;
			stop_seen <= 1'b0;
			bit_cnt <= `I2CS_CNT_ZERO;
			shift <= '0;
			state <= I2CS_IDLE;
			ack_pend <= 1'b0;
			ptr <= `I2CS_PTR_RESET;
			ptr_tgl <= 1'b0;
			wr_tgl <= 1'b0;
			wr_req <= '0;
		end else begin
			start_seen <= start_tgl;
			stop_seen <= stop_tgl;
			bit_cnt <= next_cnt;
			shift <= {shift[5:0], sda_i};
			state <= next_state;
			ack_pend <= next_ack;
			if (ptr_load || ptr_step) begin
				ptr <= next_ptr; // (R18)
				ptr_tgl <= ~ptr_tgl;
			end
			if (wr_fire) begin
				wr_req <= '{addr: ptr, data: rx_byte};
				wr_tgl <= ~wr_tgl;
			end
		end
	end

	// ****************************************
	// Link domain: drive side on falling SCL
	// ****************************************
	logic [7:0] tx;

	wire pending = start_new || stop_new;
	wire load_tx = (state == I2CS_RDATA) && (bit_cnt == `I2CS_CNT_ZERO); // (R11) (R14)
	wire in_tx = (state == I2CS_RDATA) && (bit_cnt != `I2CS_CNT_ZERO) && (bit_cnt <= `I2CS_BIT_LAST);
	wire [2:0] tx_idx = `I2CS_MSB_IDX - bit_cnt[2:0];
	wire drive_ack = ack_clock && ack_pend;
	// Enable high pulls the line low; a one on the wire is a release.
	wire next_oe = pending ? 1'b0 :
		drive_ack ? 1'b1 :
		load_tx ? ~rd_hold[7] :
		in_tx ? ~tx[tx_idx] : 1'b0;

	always_ff @(negedge scl or negedge rst_n) begin
		if (!rst_n) begin
			sda_o <= 1'b0;
			sda_oe <= 1'b0;
			tx <= `I2CS_BYTE_RESET;
		end else begin
			sda_o <= 1'b0;
			sda_oe <= next_oe; // (R6) (R9)
			if (load_tx) begin
				tx <= rd_hold; // (R11)
			end
		end
	end

	// ****************************************
	// Crossing into clk: toggles through two flops
	// ****************************************
	// Words beside each toggle are held until the next toggle, which is at least
	// one full SCL bit away; even at 400 kHz that dwarfs the few clk cycles used.
	logic [`I2CS_EV_COUNT-1:0] ev_meta;
	logic [`I2CS_EV_COUNT-1:0] ev_sync;
	logic [`I2CS_EV_COUNT-1:0] ev_last;
	logic [MEM_AW-1:0] fetch_addr;
	logic mem_we;
	i2cs_wr_type mem_wr;

	wire [`I2CS_EV_COUNT-1:0] ev_raw = {stop_tgl, start_tgl, wr_tgl, ptr_tgl};
	wire [`I2CS_EV_COUNT-1:0] ev_edge = ev_sync ^ ev_last;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ev_meta <= `I2CS_EV_RESET;
			ev_sync <= `I2CS_EV_RESET;
			ev_last <= `I2CS_EV_RESET;
		end else begin
			ev_meta <= ev_raw;
			ev_sync <= ev_meta;
			ev_last <= ev_sync;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fetch_addr <= '0;
			mem_we <= 1'b0;
			mem_wr <= '0;
		end else begin
			mem_we <= ev_edge[`I2CS_EV_WR];
			if (ev_edge[`I2CS_EV_PTR]) begin
				fetch_addr <= ptr[MEM_AW-1:0]; // (R15)
			end
			if (ev_edge[`I2CS_EV_WR]) begin
				mem_wr <= wr_req; // (R16) (R17)
			end
		end
	end

	// A start seen together with a stop leaves the bus busy.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_busy <= 1'b0;
		end else if (ev_edge[`I2CS_EV_START]) begin
			bus_busy <= 1'b1; // (R2)
		end else if (ev_edge[`I2CS_EV_STOP]) begin
			bus_busy <= 1'b0; // (R2)
		end
	end

	assign wr_pulse = mem_we;
	assign wr_addr = mem_wr.addr;
	assign wr_data = mem_wr.data;

	// ****************************************
	// Register storage
	// ****************************************
	i2cs_regmem #(
		.AW(MEM_AW),
		.DW(8)
	) u_regmem (
		.clk(clk),
		.rst_n(rst_n),
		.we(mem_we),
		.waddr(mem_wr.addr[MEM_AW-1:0]),
		.wdata(mem_wr.data),
		.a_addr(fetch_addr),
		.a_data(rd_hold),
		.b_addr(usr_addr),
		.b_data(usr_data)
	);

endmodule

// >>> i2cs_slave_props.sv
`timescale 1ns/100ps
module i2cs_slave_props import i2cs_pkg::*; #(
	parameter int MEM_AW = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Link
	input wire logic scl,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	// Core side
	input wire logic [MEM_AW-1:0] usr_addr,
	input wire logic [7:0] usr_data,
	input wire logic wr_pulse,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic bus_busy
);
	// ****************************************
	// Cycles since the last bus condition
	// ****************************************
	logic [3:0] since_start;
	logic [3:0] since_stop;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence start_seen;
		$fell(sda_i) && scl && $past(scl);
	endsequence
	sequence stop_seen;
		$rose(sda_i) && scl && $past(scl);
	endsequence
	// Saturating, so a quiet bus never wraps into a false match
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			since_start <= 4'hf;
			since_stop <= 4'hf;
		end else begin
			since_start <= ($fell(sda_i) && scl && $past(scl)) ? 4'h0 : since_start + {3'h0, since_start != 4'hf};
			since_stop <= ($rose(sda_i) && scl && $past(scl)) ? 4'h0 : since_stop + {3'h0, since_stop != 4'hf};
		end
	end
	a_sda_o_low: assert property (sda_o == 1'b0) else $error("sda_o not low");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl) else $error("sda_oe moved with scl high");
	a_pulse_single: assert property (wr_pulse |=> !wr_pulse) else $error("write pulse too long");
	a_wr_hold: assert property ($changed(wr_addr) || $changed(wr_data) |-> wr_pulse) else $error("write data moved");
	a_pulse_busy: assert property (wr_pulse |-> bus_busy) else $error("write outside transfer");
	a_busy_start: assert property (start_seen |-> ##[1:6] bus_busy) else $error("busy missed start");
	a_busy_stop: assert property (stop_seen |-> ##[1:6] !bus_busy) else $error("busy missed stop");
	a_busy_rise: assert property ($rose(bus_busy) |-> since_start <= 4'h6) else $error("busy without start");
	a_busy_fall: assert property ($fell(bus_busy) |-> since_stop <= 4'h6) else $error("busy dropped early");
	a_idle_release: assert property (!bus_busy |-> !sda_oe) else $error("sda driven on idle bus");
endmodule
bind i2cs_slave i2cs_slave_props #(.MEM_AW(MEM_AW)) props_u (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe(sda_oe), .usr_addr(usr_addr), .usr_data(usr_data), .wr_pulse(wr_pulse),
	.wr_addr(wr_addr), .wr_data(wr_data), .bus_busy(bus_busy));

// >>> i2cs_slave_tb_top.sv
`timescale 1ns/100ps
module i2cs_slave_tb_top import i2cs_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b1;
	logic [7:0] usr_addr = 8'h00;
	logic [7:0] usr_data, wr_addr, wr_data, d;
	logic wr_pulse, bus_busy, sda_o, sda_oe, scl, m_low, a;
	wire sda = !sda_oe && !m_low;
	int fails = 0;
	int check_count = 0;
	int npulse = 0;
	always #4 clk = ~clk;
	// Counted on the falling edge, where the pulse has settled
	always @(negedge clk) if (wr_pulse === 1'b1) npulse++;
	i2cs_host_model m_u (.scl(scl), .sda_low(m_low), .sda(sda));
	i2cs_slave dut_u (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.usr_addr(usr_addr), .usr_data(usr_data), .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data),
		.bus_busy(bus_busy));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d fails=%0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_write();
		m_u.start();
		m_u.wbyte(8'h3a, a);
		chk_bit(a, 1'b1);
		chk_bit(bus_busy, 1'b1);
		m_u.wbyte(8'h10, a);
		chk_bit(a, 1'b1);
		m_u.wbyte(8'h55, a);
		chk_bit(a, 1'b1);
		m_u.wbyte(8'ha6, a);
		chk_bit(a, 1'b1);
		m_u.wbyte(8'h3c, a);
		chk_bit(a, 1'b1);
		chk(8'(npulse), 8'h03);
		chk(wr_addr, 8'h12);
		chk(wr_data, 8'h3c);
		m_u.stop();
		#200 chk_bit(bus_busy, 1'b0);
	endtask
	task automatic t_read();
		m_u.start();
		m_u.wbyte(8'h3a, a);
		chk_bit(a, 1'b1);
		m_u.wbyte(8'h10, a);
		chk_bit(a, 1'b1);
		m_u.start();
		m_u.wbyte(8'h3b, a);
		chk_bit(a, 1'b1);
		m_u.rbyte(1'b1, d);
		chk(d, 8'h55);
		m_u.rbyte(1'b0, d);
		chk(d, 8'ha6);
		m_u.stop();
		chk_bit(bus_busy, 1'b0);
	endtask
	// Pointer set at 100 kHz; the next scenario reads from it
	task automatic t_slow();
		m_u.q = 2500;
		m_u.start();
		m_u.wbyte(8'h3a, a);
		chk_bit(a, 1'b1);
		m_u.wbyte(8'h11, a);
		chk_bit(a, 1'b1);
		m_u.stop();
		m_u.q = 625;
	endtask
	task automatic t_foreign();
		m_u.start();
		m_u.wbyte(8'h3c, a);
		chk_bit(a, 1'b0);
		m_u.wbyte(8'h10, a);
		chk_bit(a, 1'b0);
		m_u.stop();
		m_u.start();
		m_u.wbyte(8'h3b, a);
		chk_bit(a, 1'b1);
		m_u.rbyte(1'b0, d);
		chk(d, 8'ha6);
		m_u.stop();
	endtask
	task automatic t_core();
		@(posedge clk) #1 usr_addr = 8'h11;
		repeat (2) @(posedge clk);
		#1 chk(usr_data, 8'ha6);
	endtask
	// Tests take about 540 us; the limit leaves a margin and stays under 90k cycles
	initial begin
		#700000;
		fails++;
		give_verdict();
	end
	// Reset falls after time zero so the link-side flops see a real edge
	initial begin
		#1 rst_n = 1'b0;
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		t_write();
		t_read();
		t_slow();
		t_foreign();
		t_core();
		give_verdict();
	end
endmodule
